/* include/flash_id_cfg.svh */
/*
  Constants of the flash identification command block: opcodes, header bit
  positions, wake delays, queue depth. Assumes a 4 ns core clock.
*/
`ifndef FLASH_ID_CFG_SVH
`define FLASH_ID_CFG_SVH

`define OP_WAKE          8'hAB
`define OP_MFR_DEV       8'h90
`define OP_STD_ID        8'h9F
`define OP_UNIQUE        8'h4B
`define OP_SLEEP         8'hB9

`define OPCODE_LAST_BIT  6'h07
`define EXT_BIT          6'h08
`define ADDR_LSB_BIT     6'h1F
`define HDR_MAX          6'h28
`define START_WAKE_ID    6'h20
`define START_MFR_DEV    6'h20
`define START_STD_ID     6'h08
`define START_UNIQUE     6'h28
`define STD_LAST_BIT     7'h17

`define MCLK_PERIOD_NS   4
`define WAKE_DELAY_NS    1000
`define WAKE_ID_DELAY_NS 800
`define EVT_FIFO_DEPTH   8

`endif

/* include/flash_id_pkg.sv */
/*
  Types shared by the identification command block and its event queue.
  Assumes flash_id_cfg.svh for numeric constants.
*/
package flash_id_pkg;

  typedef enum logic [2:0] {M_NONE, M_WAKE_ID, M_MFR_DEV, M_STD_ID, M_UNIQUE} mode_t;
  typedef enum logic [1:0] {P_AWAKE, P_SLEEP, P_WAKING} pwr_t;

  // one frame event handed from the link side to the core side
  typedef struct packed {
    logic [7:0] opcode;
    logic       ext;
    logic       frame_end;
  } evt_t;

  // link state cleared by chip select
  typedef struct packed {
    logic [5:0] cnt;
    logic [7:0] shreg;
    mode_t      mode;
    logic       a0;
    logic [6:0] dk;
    logic       slp_q1;
    logic       slp_q2;
    logic       busy_q1;
    logic       busy_q2;
  } frm_t;

  // link state that must outlive a frame
  typedef struct packed {
    logic [7:0] opcode;
    logic       op_tgl;
    logic       ext_tgl;
  } tgl_t;

  typedef struct packed {
    logic so;
    logic oe;
  } out_t;

  typedef struct packed {
    logic       cs_q1;
    logic       cs_q2;
    logic       cs_q3;
    logic       op_q1;
    logic       op_q2;
    logic       op_seen;
    logic       ext_q1;
    logic       ext_q2;
    logic       ext_seen;
    logic       end_pend;
    pwr_t       pwr;
    logic [7:0] cur_op;
    logic       cur_ext;
    logic [15:0] timer;
  } core_t;

endpackage : flash_id_pkg

/* core/evt_fifo.sv */
/*
  Single-clock valid/ready FIFO with parameter width and depth.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module evt_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input  wire logic         i_mclk,   // core clock
  input  wire logic         i_rst,    // async reset, high
  input  wire logic [W-1:0] i_data,   // write word
  input  wire logic         i_valid,  // write request
  output logic              o_ready,  // room for a word
  output logic      [W-1:0] o_data,   // head word
  output logic              o_valid,  // head present
  input  wire logic         i_ready   // reader takes head
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  // full and empty straight from the occupancy count
  assign o_ready = (count != (AW+1)'(D));
  assign o_valid = (count != '0);
  assign o_data  = mem[rp];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  // storage has no reset; only pointers matter
  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem[wp] <= i_data;
    end
  end

  // pointers wrap, depth is a power of two
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wp <= wp + 1'b1;
      end
      if (pop)
      begin
        rp <= rp + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : evt_fifo

`default_nettype wire

/* core/flash_id_cmds.sv */
/*
  Identification and wake command handling of a serial flash: link logic
  on the serial clock decodes opcodes and shifts identifiers out, core
  logic on i_mclk keeps the deep sleep state and wake delays.
  Assumes the serial clock stands still while chip select is high, and
  that i_busy comes from core-clock logic.
*/
// What this block does
// (R01) bare wake opcode then chip select high: leave sleep after wake delay
// (R02) host keeps chip select high throughout the wake delay
// (R03) wake opcode plus three dummy bytes: device id out MSB first, falling
// (R04) device id repeats while clock runs; chip select high ends output
// (R05) wake-with-id from sleep: normal operation after the second delay
// (R06) wake/id opcode ignored while busy, ongoing cycle untouched
// (R07) 0x90 with address zero: manufacturer id then device id out
// (R08) 0x90 with address one: device id first, manufacturer second
// (R09) 0x90 output alternates both ids until chip select rises
// (R10) standard id: manufacturer, memory type, capacity, MSB first
// (R11) unique opcode, address, one dummy byte: 128-bit number out
// (R12) opcode, address and dummy bits sampled on rising serial clock
// (R13) in deep sleep only the wake opcode is recognised
// (R14) output undriven while deselected and during header phases
`timescale 1ns/10ps
`default_nettype none
`include "flash_id_cfg.svh"

module flash_id_cmds #(
  parameter logic [7:0]   MFR_ID    = 8'hA5,  // arbitrary value
  parameter logic [7:0]   DEV_ID    = 8'h3C,  // arbitrary value
  parameter logic [7:0]   MEM_TYPE  = 8'h61,  // arbitrary value
  parameter logic [7:0]   CAPACITY  = 8'h13,  // arbitrary value
  parameter logic [127:0] UNIQUE_ID = 128'h0123456789ABCDEF_FEDCBA9876543210 // arbitrary
) (
  input  wire logic i_mclk,          // core clock, 250 MHz
  input  wire logic i_rst,           // async reset, high
  input  wire logic i_busy,          // program/erase in progress
  input  wire logic i_sclk,          // serial clock from host
  input  wire logic i_cs_n,          // chip select, low active
  input  wire logic i_serial_in_pin, // serial data in
  output logic      o_so,            // serial data out
  output logic      o_so_oe,         // high while driving o_so
  output logic      o_deep_sleep,    // not in normal operation
  output logic      o_cmd_ready      // normal operation
);
  localparam int WAKE_CYC =
    (`WAKE_DELAY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
  localparam int WAKE_ID_CYC =
    (`WAKE_ID_DELAY_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;
  localparam int WAKE_LAST    = WAKE_CYC - 1;
  localparam int WAKE_ID_LAST = WAKE_ID_CYC - 1;
  localparam int EVT_W        = $bits(flash_id_pkg::evt_t);

  flash_id_pkg::frm_t f;
  flash_id_pkg::frm_t next_f;
  flash_id_pkg::tgl_t t;
  flash_id_pkg::tgl_t next_t;
  flash_id_pkg::out_t o;
  flash_id_pkg::out_t next_o;
  flash_id_pkg::core_t c;
  flash_id_pkg::core_t next_c;
  flash_id_pkg::evt_t evt_in;
  flash_id_pkg::evt_t evt_out;
  logic link_rst;
  logic evt_in_valid;
  logic evt_in_ready;
  logic evt_out_valid;
  logic evt_out_ready;
  logic pop;
  logic [7:0] op_now;

  // opcode to mode; asleep or busy narrows what is recognised
  function automatic flash_id_pkg::mode_t decode(input logic [7:0] op,
                                                 input logic asleep,
                                                 input logic busy);
    flash_id_pkg::mode_t m;
    m = flash_id_pkg::M_NONE;
    if (op == `OP_WAKE)
    begin
      m = busy ? flash_id_pkg::M_NONE : flash_id_pkg::M_WAKE_ID; // [R06]
    end
    else if (!asleep) // [R13]
    begin
      unique case (op)
        `OP_MFR_DEV: m = flash_id_pkg::M_MFR_DEV;
        `OP_STD_ID:  m = flash_id_pkg::M_STD_ID;
        `OP_UNIQUE:  m = flash_id_pkg::M_UNIQUE;
        default:     m = flash_id_pkg::M_NONE;
      endcase
    end
    return m;
  endfunction : decode

  // header length before the first output bit
  function automatic logic [5:0] start_of(input flash_id_pkg::mode_t m);
    logic [5:0] s;
    s = `HDR_MAX;
    unique case (m)
      flash_id_pkg::M_WAKE_ID: s = `START_WAKE_ID;
      flash_id_pkg::M_MFR_DEV: s = `START_MFR_DEV;
      flash_id_pkg::M_STD_ID:  s = `START_STD_ID;
      flash_id_pkg::M_UNIQUE:  s = `START_UNIQUE;
      flash_id_pkg::M_NONE:    s = `HDR_MAX;
    endcase
    return s;
  endfunction : start_of

  // output bit number dk of the current mode, MSB first
  function automatic logic id_bit(input flash_id_pkg::mode_t m,
                                  input logic [6:0] dk,
                                  input logic a0);
    logic [7:0] b;
    logic r;
    b = DEV_ID;
    r = 1'b0;
    unique case (m)
      flash_id_pkg::M_WAKE_ID: b = DEV_ID;                          // [R03] [R04]
      flash_id_pkg::M_MFR_DEV: b = (dk[3] ^ a0) ? DEV_ID : MFR_ID;  // [R07] [R08] [R09]
      flash_id_pkg::M_STD_ID:                                       // [R10]
        b = (dk < 7'h08) ? MFR_ID : ((dk < 7'h10) ? MEM_TYPE : CAPACITY);
      flash_id_pkg::M_UNIQUE:  b = 8'h00;
      flash_id_pkg::M_NONE:    b = 8'h00;
    endcase
    if (m == flash_id_pkg::M_UNIQUE)
    begin
      r = UNIQUE_ID[7'h7F - dk]; // [R11]
    end
    else if (m == flash_id_pkg::M_STD_ID)
    begin
      r = b[3'h7 - 3'(dk % 7'h08)];
    end
    else
    begin
      r = b[3'h7 - dk[2:0]];
    end
    return r;
  endfunction : id_bit

  // link state dies with the frame; chip select high is its reset
  assign link_rst = i_rst | i_cs_n;
  assign op_now   = {f.shreg[6:0], i_serial_in_pin};

  // link side: sample header bits, decode, advance data bit index
  always_comb
  begin
    next_f         = f;
    next_t         = t;
    next_f.slp_q1  = o_deep_sleep;
    next_f.slp_q2  = f.slp_q1;
    next_f.busy_q1 = i_busy;
    next_f.busy_q2 = f.busy_q1;
    next_f.shreg   = op_now; // [R12]
    if (f.cnt != `HDR_MAX)
    begin
      next_f.cnt = f.cnt + 6'h01;
    end
    if (f.cnt == `OPCODE_LAST_BIT)
    begin
      next_f.mode   = decode(op_now, f.slp_q2, f.busy_q2);
      next_t.opcode = op_now;
      next_t.op_tgl = ~t.op_tgl;
    end
    if (f.cnt == `EXT_BIT)
    begin
      next_t.ext_tgl = ~t.ext_tgl; // frame went past the opcode
    end
    if (f.cnt == `ADDR_LSB_BIT)
    begin
      next_f.a0 = i_serial_in_pin; // picks id order for 0x90
    end
    if (f.mode != flash_id_pkg::M_NONE && f.cnt >= start_of(f.mode))
    begin
      if (f.mode == flash_id_pkg::M_STD_ID && f.dk == `STD_LAST_BIT)
      begin
        next_f.dk = 7'h00;
      end
      else
      begin
        next_f.dk = f.dk + 7'h01; // wraps, so ids repeat
      end
    end
  end

  always_ff @(posedge i_sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      f <= '0;
    end
    else
    begin
      f <= next_f;
    end
  end

  // toggles survive frames so the core can see each event once
  always_ff @(posedge i_sclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      t <= '0;
    end
    else
    begin
      t <= next_t;
    end
  end

  // drive data on falling edges once the header is complete
  always_comb
  begin
    next_o.oe = (f.mode != flash_id_pkg::M_NONE) && (f.cnt >= start_of(f.mode)); // [R14]
    next_o.so = next_o.oe ? id_bit(f.mode, f.dk, f.a0) : 1'b0;
  end

  always_ff @(negedge i_sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      o <= '0; // [R04] [R09]
    end
    else
    begin
      o <= next_o;
    end
  end

  assign o_so    = o.so;
  assign o_so_oe = o.oe;

  // events queue up while a wake delay holds the power state machine
  evt_fifo #(
    .W (EVT_W),
    .D (`EVT_FIFO_DEPTH)
  ) u_evt_fifo (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_data  (evt_in),
    .i_valid (evt_in_valid),
    .o_ready (evt_in_ready),
    .o_data  (evt_out),
    .o_valid (evt_out_valid),
    .i_ready (evt_out_ready)
  );

  assign evt_out_ready = (c.pwr != flash_id_pkg::P_WAKING);
  assign pop           = evt_out_valid & evt_out_ready;

  // core side: synchronise, queue events, run power state
  always_comb
  begin
    next_c        = c;
    next_c.cs_q1  = i_cs_n;
    next_c.cs_q2  = c.cs_q1;
    next_c.cs_q3  = c.cs_q2;
    next_c.op_q1  = t.op_tgl;
    next_c.op_q2  = c.op_q1;
    next_c.ext_q1 = t.ext_tgl;
    next_c.ext_q2 = c.ext_q1;
    evt_in        = '0;
    evt_in_valid  = (c.op_q2 != c.op_seen) | (c.ext_q2 != c.ext_seen) | c.end_pend;
    // opcode is stable long before its toggle arrives here
    if (c.op_q2 != c.op_seen)
    begin
      evt_in.opcode = t.opcode;
      if (evt_in_ready)
      begin
        next_c.op_seen = c.op_q2;
      end
    end
    else if (c.ext_q2 != c.ext_seen)
    begin
      evt_in.ext = 1'b1;
      if (evt_in_ready)
      begin
        next_c.ext_seen = c.ext_q2;
      end
    end
    else
    begin
      evt_in.frame_end = 1'b1;
      if (evt_in_ready)
      begin
        next_c.end_pend = 1'b0;
      end
    end
    // a new frame end wins over clearing the old one
    if (c.cs_q2 && !c.cs_q3)
    begin
      next_c.end_pend = 1'b1;
    end
    if (c.pwr == flash_id_pkg::P_WAKING)
    begin
      if (c.timer == 16'h0000)
      begin
        next_c.pwr = flash_id_pkg::P_AWAKE; // [R01] [R05]
      end
      else
      begin
        next_c.timer = c.timer - 16'h0001;
      end
    end
    if (pop)
    begin
      if (evt_out.frame_end)
      begin
        next_c.cur_op  = 8'h00;
        next_c.cur_ext = 1'b0;
        unique case (c.pwr)
          flash_id_pkg::P_AWAKE:
            if (c.cur_op == `OP_SLEEP && !c.cur_ext && !i_busy)
            begin
              next_c.pwr = flash_id_pkg::P_SLEEP;
            end
          flash_id_pkg::P_SLEEP:
            if (c.cur_op == `OP_WAKE && !i_busy) // [R06] [R13]
            begin
              next_c.pwr   = flash_id_pkg::P_WAKING;
              next_c.timer = c.cur_ext ? 16'(WAKE_ID_LAST) : 16'(WAKE_LAST); // [R01] [R05]
            end
          flash_id_pkg::P_WAKING:
            next_c.pwr = c.pwr;
        endcase
      end
      else if (evt_out.ext)
      begin
        next_c.cur_ext = 1'b1;
      end
      else
      begin
        next_c.cur_op = evt_out.opcode;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      c       <= '0;
      c.cs_q1 <= 1'b1;
      c.cs_q2 <= 1'b1;
      c.cs_q3 <= 1'b1;
    end
    else
    begin
      c <= next_c;
    end
  end

  assign o_deep_sleep = (c.pwr != flash_id_pkg::P_AWAKE);
  assign o_cmd_ready  = (c.pwr == flash_id_pkg::P_AWAKE);

  // wake delays, measured from the frame end taken from the queue
  wake_bare_time_a: assert property ( // [R01]
    @(posedge i_mclk) disable iff (i_rst)
    (pop && evt_out.frame_end && c.pwr == flash_id_pkg::P_SLEEP &&
     c.cur_op == `OP_WAKE && !c.cur_ext && !i_busy)
    |=> ##WAKE_LAST (c.pwr == flash_id_pkg::P_WAKING) ##1 o_cmd_ready)
    else $error("bare wake delay wrong");

  wake_id_time_a: assert property ( // [R05]
    @(posedge i_mclk) disable iff (i_rst)
    (pop && evt_out.frame_end && c.pwr == flash_id_pkg::P_SLEEP &&
     c.cur_op == `OP_WAKE && c.cur_ext && !i_busy)
    |=> ##WAKE_ID_LAST (c.pwr == flash_id_pkg::P_WAKING) ##1 o_cmd_ready)
    else $error("wake with id delay wrong");

  busy_wake_a: assert property ( // [R06]
    @(posedge i_mclk) disable iff (i_rst)
    (pop && evt_out.frame_end && c.pwr == flash_id_pkg::P_SLEEP && i_busy)
    |=> (c.pwr == flash_id_pkg::P_SLEEP))
    else $error("wake taken while busy");

  sleep_filter_a: assert property ( // [R13]
    @(posedge i_mclk) disable iff (i_rst)
    (c.pwr == flash_id_pkg::P_SLEEP && c.cur_op != `OP_WAKE)
    |=> $stable(o_deep_sleep) && c.pwr == flash_id_pkg::P_SLEEP)
    else $error("sleep left without wake");

  // link checks: rising edge sees what the last falling edge drove
  quiet_header_a: assert property ( // [R14]
    @(posedge i_sclk) disable iff (link_rst)
    (f.mode == flash_id_pkg::M_NONE || f.cnt < start_of(f.mode)) |-> !o_so_oe)
    else $error("output driven in header");

  opcode_capture_a: assert property ( // [R12]
    @(posedge i_sclk) disable iff (link_rst)
    (f.cnt == `EXT_BIT) |-> (t.opcode == f.shreg && $past(f.cnt) == `OPCODE_LAST_BIT))
    else $error("opcode not sampled");

  wake_id_bits_a: assert property ( // [R03] [R04]
    @(posedge i_sclk) disable iff (link_rst)
    (f.mode == flash_id_pkg::M_WAKE_ID && o_so_oe) |-> o_so == DEV_ID[3'h7 - f.dk[2:0]])
    else $error("device id bit wrong");

  mfr_dev_order_a: assert property ( // [R07] [R08] [R09]
    @(posedge i_sclk) disable iff (link_rst)
    (f.mode == flash_id_pkg::M_MFR_DEV && o_so_oe && f.dk[3] == f.a0)
    |-> o_so == MFR_ID[3'h7 - f.dk[2:0]])
    else $error("id order wrong");

  std_id_first_a: assert property ( // [R10]
    @(posedge i_sclk) disable iff (link_rst)
    (f.mode == flash_id_pkg::M_STD_ID && f.cnt == `START_STD_ID && f.dk == 7'h00)
    |-> o_so_oe && o_so == MFR_ID[7])
    else $error("standard id start wrong");

  uniq_bits_a: assert property ( // [R11]
    @(posedge i_sclk) disable iff (link_rst)
    (f.mode == flash_id_pkg::M_UNIQUE && o_so_oe) |-> o_so == UNIQUE_ID[7'h7F - f.dk])
    else $error("unique id bit wrong");

endmodule : flash_id_cmds

`default_nettype wire

/* dv/spi_host_model.sv */
/*
  Behavioural host controller for the identification command block.
  Assumes the device samples on rising and shifts on falling clock edges.
*/
`timescale 1ns/10ps
`default_nettype none

module spi_host_model (
  output logic      o_sclk,   // serial clock, 30 ns, still between frames
  output logic      o_cs_n,   // chip select, low active
  output logic      o_sdi,    // serial data towards the device
  input  wire logic i_so,     // serial data from the device
  input  wire logic i_so_oe   // device drives i_so
);
  // idle: clock low, deselected
  initial
  begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
  end

  // one whole frame: nh header bits msb first, then nr bits read back
  task automatic xfer(input logic [39:0] hdr, input int nh, input int nr,
                      output logic [127:0] rd, output logic hdr_oe, output int oe_cnt);
    begin
      rd = '0;
      hdr_oe = 1'b0;
      oe_cnt = 0;
      o_cs_n = 1'b0;
      for (int i = 0; i < nh; i++)
      begin
        o_sdi = hdr[39-i];         // changed while clock low
        #15 o_sclk = 1'b1;
        hdr_oe = hdr_oe | i_so_oe; // header phase must stay undriven
        #15 o_sclk = 1'b0;
      end
      for (int j = 0; j < nr; j++)
      begin
        #15 o_sclk = 1'b1;
        rd = {rd[126:0], i_so};
        if (i_so_oe === 1'b1)
          oe_cnt++;
        #15 o_sclk = 1'b0;
      end
      #15 o_cs_n = 1'b1;
      o_sdi = ~o_sdi;              // released line shows no stale value
    end
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* dv/spi_flash_id_and_wake_cmds_tb.sv */
/*
  Self-checking bench of the identification and wake commands.
  Assumes the host model in spi_host_model.sv and the constants header.
*/
`timescale 1ns/10ps
`default_nettype none
`include "flash_id_cfg.svh"

module spi_flash_id_and_wake_cmds_tb;
  localparam logic [7:0]   MFR  = 8'h5A;
  localparam logic [7:0]   DEV  = 8'hC3;
  localparam logic [7:0]   MEMT = 8'h16;
  localparam logic [7:0]   CAP  = 8'h31;
  localparam logic [127:0] UID  = 128'h00112233445566778899AABBCCDDEEFF;
  localparam int           WAKE = `WAKE_DELAY_NS / `MCLK_PERIOD_NS;
  localparam int           WKID = `WAKE_ID_DELAY_NS / `MCLK_PERIOD_NS;

  typedef struct {
    logic [39:0]  hdr;
    int           nh;
    int           nr;
    logic [127:0] exp;
  } row_t;

  logic         mclk, rst, busy, sclk, cs_n, sdi, so, so_oe, deep_sleep, cmd_ready;
  logic [127:0] rd;
  logic         hoe;
  int           oe_cnt, n, fail_count, compares;
  row_t         rows [5];

  flash_id_cmds #(.MFR_ID(MFR), .DEV_ID(DEV), .MEM_TYPE(MEMT), .CAPACITY(CAP),
                  .UNIQUE_ID(UID)) dut (
    .i_mclk(mclk), .i_rst(rst), .i_busy(busy), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_in_pin(sdi), .o_so(so), .o_so_oe(so_oe), .o_deep_sleep(deep_sleep),
    .o_cmd_ready(cmd_ready));

  spi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi), .i_so(so), .i_so_oe(so_oe));

  // free-running core clock
  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    begin
      compares++;
      if (got !== exp)
      begin
        fail_count++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask : check

  task automatic end_of_test;
    begin
      if (fail_count == 0 && compares > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask : end_of_test

  // deselected gap long enough for the core side to see the frame end
  task automatic gap;
    repeat (8) @(negedge mclk);
  endtask : gap

  // cycles until normal operation, bounded so a stuck sleep cannot hang
  task automatic wait_ready(output int cyc);
    begin
      cyc = 0;
      while (cmd_ready !== 1'b1 && cyc < 400)
      begin
        @(negedge mclk);
        cyc++;
      end
    end
  endtask : wait_ready

  task automatic sleep_now;
    begin
      host.xfer({8'hB9, 32'h0}, 8, 0, rd, hoe, oe_cnt);
      gap();
      gap();
      check({126'h0, deep_sleep, cmd_ready}, 128'h2);
    end
  endtask : sleep_now

  // watchdog, well past the few tens of microseconds the tests need
  initial
  begin
    #200000;
    fail_count++;
    end_of_test();
  end

  initial
  begin
    rows[0] = '{{8'h9F, 32'h0}, 8, 48, {80'h0, MFR, MEMT, CAP, MFR, MEMT, CAP}};
    rows[1] = '{{8'h90, 32'h0}, 32, 32, {96'h0, MFR, DEV, MFR, DEV}};
    rows[2] = '{{8'h90, 24'h1, 8'h0}, 32, 32, {96'h0, DEV, MFR, DEV, MFR}};
    rows[3] = '{{8'hAB, 32'h0}, 32, 24, {104'h0, DEV, DEV, DEV}};
    rows[4] = '{{8'h4B, 32'h0}, 40, 128, UID};
    fail_count = 0;
    compares = 0;
    rst = 1'b1;
    busy = 1'b0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    check({125'h0, deep_sleep, cmd_ready, so_oe}, 128'h2);
    // ordinary reads: data, header silence, driven count, release at deselect
    for (int k = 0; k < 5; k++)
    begin
      host.xfer(rows[k].hdr, rows[k].nh, rows[k].nr, rd, hoe, oe_cnt);
      check(rd, rows[k].exp);
      check({hoe, oe_cnt[7:0]}, {1'b0, rows[k].nr[7:0]});
      gap();
      check({127'h0, so_oe}, 128'h0);
    end
    // awake but unknown opcode: never drives, even with clocks after the header
    host.xfer({8'h03, 32'h0}, 32, 16, rd, hoe, oe_cnt);
    check({hoe, oe_cnt[7:0]}, {1'b0, 8'h00});
    gap();
    // asleep: identification reads refused
    sleep_now();
    host.xfer({8'h9F, 32'h0}, 8, 24, rd, hoe, oe_cnt);
    check(oe_cnt, 0);
    gap();
    check({127'h0, deep_sleep}, 128'h1);
    // bare wake: cs held high for the full delay
    host.xfer({8'hAB, 32'h0}, 8, 0, rd, hoe, oe_cnt);
    wait_ready(n);
    check({127'h0, n >= WAKE && n <= WAKE + 12}, 128'h1);
    // wake with identifier from sleep, shorter delay
    sleep_now();
    host.xfer({8'hAB, 32'h0}, 32, 8, rd, hoe, oe_cnt);
    check(rd, {120'h0, DEV});
    wait_ready(n);
    check({127'h0, n >= WKID && n <= WKID + 12}, 128'h1);
    // busy: wake/identifier ignored while awake and while asleep
    @(negedge mclk);
    busy = 1'b1;
    host.xfer({8'hAB, 32'h0}, 32, 8, rd, hoe, oe_cnt);
    check(oe_cnt, 0);
    // the ignored frame still needs its frame end seen before the next one
    gap();
    busy = 1'b0;
    sleep_now();
    @(negedge mclk);
    busy = 1'b1;
    host.xfer({8'hAB, 32'h0}, 8, 0, rd, hoe, oe_cnt);
    repeat (300) @(negedge mclk);
    check({127'h0, deep_sleep}, 128'h1);
    busy = 1'b0;
    host.xfer({8'hAB, 32'h0}, 8, 0, rd, hoe, oe_cnt);
    wait_ready(n);
    check({127'h0, cmd_ready}, 128'h1);
    // reset in mid-run while asleep returns to normal operation
    sleep_now();
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    check({126'h0, deep_sleep, cmd_ready}, 128'h1);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    host.xfer(rows[0].hdr, 8, 24, rd, hoe, oe_cnt);
    check(rd, {104'h0, MFR, MEMT, CAP});
    gap();
    end_of_test();
  end
endmodule : spi_flash_id_and_wake_cmds_tb
`default_nettype wire
